// file: hw/rlc_cfg_regs.svh
// Register offsets, field positions, reset values and timing figures of the link configuration bank
`ifndef RLC_CFG_REGS_SVH
`define RLC_CFG_REGS_SVH

`define RLC_ADDR_W            5
`define RLC_OFF_ADDR_WIDTH    5'h03
`define RLC_OFF_RETRANSMIT    5'h04
`define RLC_OFF_CHANNEL       5'h05
`define RLC_OFF_RADIO_SETUP   5'h06

`define RLC_AW_LSB            0
`define RLC_AW_MSB            1
`define RLC_DELAY_LSB         4
`define RLC_DELAY_MSB         7
`define RLC_COUNT_LSB         0
`define RLC_COUNT_MSB         3
`define RLC_CHAN_LSB          0
`define RLC_CHAN_MSB          6
`define RLC_CARRIER_BIT       7
`define RLC_LOW_RATE_BIT      5
`define RLC_LOCK_BIT          4
`define RLC_HIGH_RATE_BIT     3

`define RLC_AW_RESET          2'h3
`define RLC_AW_ILLEGAL        2'h0
`define RLC_DELAY_RESET       4'h0
`define RLC_COUNT_RESET       4'h3
`define RLC_CHAN_RESET        7'h02

`define RLC_CLK_MHZ           100
`define RLC_RETR_STEP_US      250
`define RLC_WAIT_W            19

`endif

// file: hw/rlc_pkg.sv
// Types shared by the link configuration bank
`default_nettype none
package rlc_pkg;
    typedef enum logic [1:0] {
        RLC_RATE_1M   = 2'b00,
        RLC_RATE_2M   = 2'b01,
        RLC_RATE_250K = 2'b10
    } rlc_rate_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [4:0] addr;
        logic [7:0] wdata;
    } rlc_reg_req_t;
endpackage : rlc_pkg
`default_nettype wire

// file: hw/rlc_cfg_bank.sv
// Link configuration register bank: address width, retransmission, channel and radio setup
`include "rlc_cfg_regs.svh"
`default_nettype none
module rlc_cfg_bank #(
    parameter int unsigned RETR_STEP_CYCLES = `RLC_RETR_STEP_US * `RLC_CLK_MHZ
) (
    input  wire logic                ref_clk_in,
    input  wire logic                sys_rst_in,
    input  wire rlc_pkg::rlc_reg_req_t reg_req_in,
    output logic [7:0]               reg_rdata_out,
    output logic [2:0]               addr_bytes_out,
    output logic [4:0]               addr_byte_mask_out,
    output logic [`RLC_WAIT_W-1:0]   retransmit_wait_cycles_out,
    output logic [3:0]               retransmit_limit_out,
    output logic [6:0]               channel_number_out,
    output logic                     carrier_test_enable_out,
    output rlc_pkg::rlc_rate_t       data_rate_out,
    output logic                     lock_force_out
);
    // Stored fields
    logic [1:0] address_width_field;
    logic [3:0] retransmit_delay_field;
    logic [3:0] retransmit_count_field;
    logic [6:0] channel_number_field;
    logic       carrier_test_enable;
    logic       low_rate_select;
    logic       high_rate_select;
    logic       lock_force;

    // Wait in clocks; nineteen bits hold sixteen steps of the default step
    function automatic logic [`RLC_WAIT_W-1:0] wait_cycles(input logic [3:0] code);
        logic [`RLC_WAIT_W-1:0] steps;
        steps = {{(`RLC_WAIT_W-4){1'b0}}, code} + `RLC_WAIT_W'(1);
        return `RLC_WAIT_W'(steps * `RLC_WAIT_W'(RETR_STEP_CYCLES));
    endfunction : wait_cycles

    // Decode of the register access path
    wire hit_aw    = reg_req_in.addr == `RLC_OFF_ADDR_WIDTH;
    wire hit_retr  = reg_req_in.addr == `RLC_OFF_RETRANSMIT;
    wire hit_chan  = reg_req_in.addr == `RLC_OFF_CHANNEL;
    wire hit_setup = reg_req_in.addr == `RLC_OFF_RADIO_SETUP;
    wire wr_aw     = reg_req_in.wr && hit_aw;
    wire wr_retr   = reg_req_in.wr && hit_retr;
    wire wr_chan   = reg_req_in.wr && hit_chan;
    wire wr_setup  = reg_req_in.wr && hit_setup;
    wire [1:0] aw_wdata = reg_req_in.wdata[`RLC_AW_MSB:`RLC_AW_LSB];
    // Illegal code would leave the radio with no address at all, so it is refused
    wire aw_take = wr_aw && (aw_wdata != `RLC_AW_ILLEGAL);

    // Reserved bits are not stored and read back as zero
    wire [7:0] rd_aw    = {6'h00, address_width_field};
    wire [7:0] rd_retr  = {retransmit_delay_field, retransmit_count_field};
    wire [7:0] rd_chan  = {1'b0, channel_number_field};
    wire [7:0] rd_setup = {carrier_test_enable, 1'b0, low_rate_select, lock_force,
                           high_rate_select, 3'h0};
    wire [7:0] next_rdata = !reg_req_in.rd ? 8'h00 :
                            hit_aw    ? rd_aw   :
                            hit_retr  ? rd_retr :
                            hit_chan  ? rd_chan :
                            hit_setup ? rd_setup : 8'h00;

    // Derived configuration
    wire [2:0] next_bytes = {1'b0, address_width_field} + 3'h2;
    wire [4:0] next_mask  = address_width_field == 2'h1 ? 5'h07 :
                            address_width_field == 2'h2 ? 5'h0F : 5'h1F;
    // Pair 11 is reserved; letting the low-rate bit win keeps the radio on a real rate
    wire rlc_pkg::rlc_rate_t next_rate =
        low_rate_select  ? rlc_pkg::RLC_RATE_250K :
        high_rate_select ? rlc_pkg::RLC_RATE_2M : rlc_pkg::RLC_RATE_1M;

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            address_width_field <= `RLC_AW_RESET;
        end else if (aw_take) begin
            address_width_field <= aw_wdata;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            retransmit_delay_field <= `RLC_DELAY_RESET;
            retransmit_count_field <= `RLC_COUNT_RESET;
        end else if (wr_retr) begin
            retransmit_delay_field <= reg_req_in.wdata[`RLC_DELAY_MSB:`RLC_DELAY_LSB];
            retransmit_count_field <= reg_req_in.wdata[`RLC_COUNT_MSB:`RLC_COUNT_LSB];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            channel_number_field <= `RLC_CHAN_RESET;
        end else if (wr_chan) begin
            channel_number_field <= reg_req_in.wdata[`RLC_CHAN_MSB:`RLC_CHAN_LSB];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            carrier_test_enable <= 1'b0;
            low_rate_select     <= 1'b0;
            high_rate_select    <= 1'b0;
            lock_force          <= 1'b0;
        end else if (wr_setup) begin
            carrier_test_enable <= reg_req_in.wdata[`RLC_CARRIER_BIT];
            low_rate_select     <= reg_req_in.wdata[`RLC_LOW_RATE_BIT];
            high_rate_select    <= reg_req_in.wdata[`RLC_HIGH_RATE_BIT];
            lock_force          <= reg_req_in.wdata[`RLC_LOCK_BIT];
        end
    end

    // Outputs lag the stored fields by one cycle so each comes from a flop
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            reg_rdata_out              <= 8'h00;
            addr_bytes_out             <= 3'h5;
            addr_byte_mask_out         <= 5'h1F;
            retransmit_wait_cycles_out <= `RLC_WAIT_W'(RETR_STEP_CYCLES);
            retransmit_limit_out       <= `RLC_COUNT_RESET;
            channel_number_out         <= `RLC_CHAN_RESET;
            carrier_test_enable_out    <= 1'b0;
            data_rate_out              <= rlc_pkg::RLC_RATE_1M;
            lock_force_out             <= 1'b0;
        end else begin
            reg_rdata_out              <= next_rdata;
            addr_bytes_out             <= next_bytes;
            addr_byte_mask_out         <= next_mask;
            retransmit_wait_cycles_out <= wait_cycles(retransmit_delay_field);
            retransmit_limit_out       <= retransmit_count_field;
            channel_number_out         <= channel_number_field;
            carrier_test_enable_out    <= carrier_test_enable;
            data_rate_out              <= next_rate;
            lock_force_out             <= lock_force;
        end
    end

    // Field outputs show a write one edge after the edge that takes it
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    aw_write_lands_a: assert property (
        aw_take |=> ##1 addr_bytes_out ==
            3'($past(aw_wdata, 2) == 2'h1 ? 3 : $past(aw_wdata, 2) == 2'h2 ? 4 : 5))
        else $error("address width write not reflected");
    aw_illegal_kept_a: assert property (
        wr_aw && aw_wdata == 2'h0 |=> $stable(address_width_field))
        else $error("illegal address width accepted");
    aw_mask_match_a: assert property (
        addr_byte_mask_out == (5'h1F >> (5 - addr_bytes_out)))
        else $error("address byte mask disagrees with width");
    delay_cycles_a: assert property (
        wr_retr |=> ##1 retransmit_wait_cycles_out ==
            `RLC_WAIT_W'(($past(reg_req_in.wdata[7:4], 2) + 1) * RETR_STEP_CYCLES))
        else $error("retransmit wait cycles wrong");
    count_write_a: assert property (
        wr_retr |=> ##1 retransmit_limit_out == $past(reg_req_in.wdata[3:0], 2))
        else $error("retransmit count not applied");
    chan_write_a: assert property (
        wr_chan |=> ##1 channel_number_out == $past(reg_req_in.wdata[6:0], 2))
        else $error("channel not applied");
    carrier_follow_a: assert property (
        wr_setup |=> ##1 carrier_test_enable_out == $past(reg_req_in.wdata[7], 2))
        else $error("carrier test bit not applied");
    rate_low_wins_a: assert property (
        wr_setup && reg_req_in.wdata[5] |=> ##1 data_rate_out == rlc_pkg::RLC_RATE_250K)
        else $error("low rate did not override high rate");
    rate_high_a: assert property (
        wr_setup && reg_req_in.wdata[5:3] == 3'b001 |=> ##1 data_rate_out == rlc_pkg::RLC_RATE_2M)
        else $error("high rate not selected");
    lock_force_a: assert property (
        wr_setup |=> ##1 lock_force_out == $past(reg_req_in.wdata[4], 2))
        else $error("lock force bit not applied");
    reserved_zero_a: assert property (
        reg_req_in.rd && hit_chan |=> reg_rdata_out[7] == 1'b0)
        else $error("reserved channel bit read non-zero");

    // Read path: idle and unmapped cycles return zero, reserved bits never leak; then field, rate and hold legality
    rdata_idle_zero_a: assert property (
        !reg_req_in.rd |=> reg_rdata_out == 8'h00)
        else $error("read data not zero without a read");
    unmapped_read_a: assert property (
        reg_req_in.rd && !(hit_aw || hit_retr || hit_chan || hit_setup) |=> reg_rdata_out == 8'h00)
        else $error("unmapped read returned data");
    aw_read_back_a: assert property (
        reg_req_in.rd && hit_aw |=> reg_rdata_out[7:2] == 6'h00 && reg_rdata_out[1:0] != `RLC_AW_ILLEGAL)
        else $error("address width readback malformed");
    setup_reserved_a: assert property (
        reg_req_in.rd && hit_setup |=> reg_rdata_out[6] == 1'b0 && reg_rdata_out[2:0] == 3'h0)
        else $error("reserved radio setup bits read non-zero");
    aw_never_zero_a: assert property (
        address_width_field != `RLC_AW_ILLEGAL)
        else $error("address width field holds the illegal code");
    rate_legal_a: assert property (
        data_rate_out != rlc_pkg::rlc_rate_t'(2'h3))
        else $error("reserved data rate code driven");
    carrier_hold_a: assert property (
        !wr_setup |=> $stable(carrier_test_enable))
        else $error("carrier test bit changed without a write");

    // Main scenarios
    cov_short_addr: cover property (aw_take && aw_wdata == 2'h1);
    cov_max_delay: cover property (wr_retr && reg_req_in.wdata[7:4] == 4'hF);
    cov_rate_250k: cover property (data_rate_out == rlc_pkg::RLC_RATE_250K);
    cov_read_setup: cover property (reg_req_in.rd && hit_setup);
    cov_both_rates: cover property (wr_setup && reg_req_in.wdata[5] && reg_req_in.wdata[3]);
endmodule : rlc_cfg_bank
`default_nettype wire

// file: tb/rlc_host_model.sv
// Host side model issuing register requests into the link configuration bank
`default_nettype none
module rlc_host_model (
    input  wire logic            ref_clk_in,
    output rlc_pkg::rlc_reg_req_t req_out,
    input  wire logic [7:0]      rdata_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req_out = '0;
    // Idle bus shows an inverted pattern so stale fields never look valid
    task automatic release_bus();
        req_out.wr = 1'b0;
        req_out.rd = 1'b0;
        req_out.addr = ~req_out.addr;
        req_out.wdata = ~req_out.wdata;
    endtask : release_bus
    // Callers pass values with reserved bits already zero
    task automatic write_reg(input logic [4:0] addr, input logic [7:0] data);
        @(posedge ref_clk_in) #1;
        req_out = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge ref_clk_in) #1;
        release_bus();
    endtask : write_reg
    task automatic read_reg(input logic [4:0] addr, output logic [7:0] data);
        @(posedge ref_clk_in) #1;
        req_out = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge ref_clk_in) #1;
        data = rdata_in;
        release_bus();
    endtask : read_reg
endmodule : rlc_host_model
`default_nettype wire

// file: tb/tb_rlc_cfg_bank.sv
// Self-checking bench for the link configuration register bank
`include "rlc_cfg_regs.svh"
`default_nettype none
module tb_rlc_cfg_bank;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned STEP = 4;
    logic                   ref_clk_in;
    logic                   sys_rst_in = 1'b1;
    rlc_pkg::rlc_reg_req_t  reg_req;
    logic [7:0]             rdata, rd_val;
    logic [2:0]             addr_bytes;
    logic [4:0]             byte_mask;
    logic [`RLC_WAIT_W-1:0] wait_cycles;
    logic [3:0]             retr_limit;
    logic [6:0]             channel;
    logic                   carrier, lock_force;
    rlc_pkg::rlc_rate_t     rate;
    logic [7:0]             retr[3] = '{8'hF0, 8'h0F, 8'h5A};
    logic [7:0]             setup[5] = '{8'h00, 8'h08, 8'h20, 8'h28, 8'h90};
    logic [1:0]             rates[5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h0};
    int                     n_mismatch = 0, total_checks = 0, cycles = 0;
    rlc_cfg_bank #(.RETR_STEP_CYCLES(STEP)) i_rlc_cfg_bank (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .reg_req_in(reg_req), .reg_rdata_out(rdata), .addr_bytes_out(addr_bytes), .addr_byte_mask_out(byte_mask),
        .retransmit_wait_cycles_out(wait_cycles), .retransmit_limit_out(retr_limit),
        .channel_number_out(channel), .carrier_test_enable_out(carrier), .data_rate_out(rate),
        .lock_force_out(lock_force));
    rlc_host_model i_rlc_host_model (.ref_clk_in(ref_clk_in), .req_out(reg_req), .rdata_in(rdata));
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize
    // A run of 3000 cycles, about thirty times what the test needs, means a hung handshake
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic rd_chk(input logic [4:0] addr, input logic [7:0] exp);
        i_rlc_host_model.read_reg(addr, rd_val);
        check(32'(rd_val), 32'(exp));
    endtask : rd_chk
    // Field outputs lag the taking edge by one edge
    task automatic wr(input logic [4:0] addr, input logic [7:0] data);
        i_rlc_host_model.write_reg(addr, data);
        @(posedge ref_clk_in) #1;
    endtask : wr
    task automatic reset_checks();
        rd_chk(5'h03, 8'h03);
        rd_chk(5'h04, 8'h03);
        rd_chk(5'h05, 8'h02);
        rd_chk(5'h06, 8'h00);
        check(32'(wait_cycles), STEP);
        check(32'(retr_limit), 32'h3);
        check(32'(channel), 32'h2);
        check(32'({carrier, lock_force, rate}), 32'h0);
        check(32'({addr_bytes, byte_mask}), 32'hBF);
    endtask : reset_checks
    initial begin
        repeat (12) @(posedge ref_clk_in);
        #1 sys_rst_in = 1'b0;
        reset_checks();
        // Ends on code 00, which must leave width 01 in place
        for (int c = 3; c >= 0; c--) begin
            wr(5'h03, 8'(c));
            check(32'(addr_bytes), ((c == 0) ? 1 : c) + 2);
            check(32'(byte_mask), (1 << (((c == 0) ? 1 : c) + 2)) - 1);
            rd_chk(5'h03, 8'((c == 0) ? 1 : c));
        end
        foreach (retr[i]) begin
            wr(5'h04, retr[i]);
            check(32'(wait_cycles), (retr[i][7:4] + 1) * STEP);
            check(32'(retr_limit), 32'(retr[i][3:0]));
            rd_chk(5'h04, retr[i]);
        end
        wr(5'h05, 8'h7F);
        check(32'(channel), 32'h7F);
        rd_chk(5'h05, 8'h7F);
        foreach (setup[i]) begin
            wr(5'h06, setup[i]);
            check(32'(rate), 32'(rates[i]));
            check(32'({carrier, lock_force}), 32'({setup[i][7], setup[i][4]}));
            rd_chk(5'h06, setup[i]);
        end
        rd_chk(5'h1F, 8'h00);
        rd_chk(5'h00, 8'h00);
        // Reset in mid-run must restore every field
        @(posedge ref_clk_in) #1 sys_rst_in = 1'b1;
        repeat (3) @(posedge ref_clk_in);
        #1 sys_rst_in = 1'b0;
        reset_checks();
        summarize();
    end
endmodule : tb_rlc_cfg_bank
`default_nettype wire
